// *** lock_pool_pkg.sv ***
// package of shared constants for the shared lock pool
// assumes a single 40 MHz clock domain and cores that issue one request at a time
package lock_pool_pkg;
    localparam int NUM_LOCKS = 8;
    localparam int ID_BITS = 3;
    localparam int NUM_CORES = 8;
    localparam int CORE_BITS = 3;
    localparam int DATA_BITS = 32;
    localparam logic [5:0] HUB_INSTR = 6'h03;
    localparam logic [2:0] SRC_CHECKOUT = 3'h4;
    localparam logic [2:0] SRC_RELEASE = 3'h5;
    localparam logic [2:0] SRC_SET = 3'h6;
    localparam logic [2:0] SRC_CLEAR = 3'h7;
    localparam int CLK_PERIOD_NS = 25;
    localparam int MIN_CLOCKS = 7;
    localparam int MAX_CLOCKS = 22;
    // one slot per core per rotation; 2 clocks per slot gives 16-clock round
    localparam int SLOT_CLOCKS = 2;
    localparam logic [7:0] LOCKS_RESET = 8'h00;
endpackage

// *** slot_rotor.sv ***
`timescale 1ns/1ps
// rotating access slot: names the core that owns the pool this slot
// assumes nothing beyond the shared clock and reset
module slot_rotor #(
    parameter int CORES = 8,
    parameter int SLOT_LEN = 2
) (
    input wire logic clk_in, // system clock
    input wire logic srst_in, // sync reset
    output logic [$clog2(CORES)-1:0] owner_out, // core owning the slot
    output logic slot_start_out // first clock of a slot
);
    logic [$clog2(SLOT_LEN+1)-1:0] tick_reg;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tick_reg <= '0;
            owner_out <= '0;
        end else if (tick_reg == $bits(tick_reg)'(SLOT_LEN - 1)) begin
            tick_reg <= '0;
            owner_out <= owner_out + 1'b1;
        end else begin
            tick_reg <= tick_reg + 1'b1;
        end
    end
    assign slot_start_out = (tick_reg == '0);
endmodule

// *** first_free.sv ***
`timescale 1ns/1ps
// priority picker: lowest index with a zero bit
// purely combinational
module first_free #(
    parameter int N = 8,
    parameter int W = 3
) (
    input wire logic [N-1:0] used_in, // allocation map
    output logic [W-1:0] idx_out, // lowest free index
    output logic none_out // no free entry
);
    always_comb begin
        idx_out = '0;
        none_out = 1'b1;
        for (int i = N - 1; i >= 0; i--) begin
            if (!used_in[i]) begin
                idx_out = W'(i);
                none_out = 1'b0;
            end
        end
    end
endmodule

// *** shared_lock_pool.sv ***
`timescale 1ns/1ps
// shared lock pool: eight lock bits plus allocation bits, reached by cores in their slot
// assumes each core holds its request level until it sees its done pulse

module shared_lock_pool #(
    parameter int CORES = lock_pool_pkg::NUM_CORES,
    parameter int LOCKS = lock_pool_pkg::NUM_LOCKS
) (
    input wire logic REF_CLK_IN, // system clock, 40 MHz
    input wire logic SRST_IN, // synchronous reset, active high
    input wire logic [CORES-1:0] REQ_IN, // per-core request level
    input wire logic [CORES*6-1:0] INSTR_IN, // per-core instruction field
    input wire logic [CORES*3-1:0] SRC_IN, // per-core immediate source
    input wire logic [CORES*32-1:0] ID_IN, // per-core ID register value
    input wire logic [CORES-1:0] ZERO_FLAG_WRITE_EFFECT_IN, // per-core zero write
    input wire logic [CORES-1:0] CARRY_FLAG_WRITE_EFFECT_IN, // per-core carry write
    input wire logic [CORES-1:0] RESULT_WRITE_IN, // per-core result bit
    output logic [CORES-1:0] DONE_OUT, // one-cycle completion pulse
    output logic [CORES-1:0] ZERO_WE_OUT, // zero flag update strobe
    output logic [CORES-1:0] ZERO_OUT, // zero flag value
    output logic [CORES-1:0] CARRY_WE_OUT, // carry flag update strobe
    output logic [CORES-1:0] CARRY_OUT, // carry flag value
    output logic [CORES-1:0] DEST_WE_OUT, // destination write strobe
    output logic [CORES*32-1:0] ALLOCATED_ID_REGISTER_OUT, // result value
    output logic [LOCKS-1:0] LOCK_STATE_OUT, // lock bits
    output logic [LOCKS-1:0] LOCK_ALLOC_OUT // allocation bits
);
    // ************************************************************
    // slot and issue timing
    // ************************************************************
    localparam int CB = $clog2(CORES);
    localparam int IB = lock_pool_pkg::ID_BITS;
    // issue takes MIN-1 clocks before slot wait; wait up to one round
    localparam int LEAD = lock_pool_pkg::MIN_CLOCKS - 2;
    localparam int ROUND = CORES * lock_pool_pkg::SLOT_CLOCKS;

    logic [CB-1:0] owner;
    logic slot_start;
    logic [IB-1:0] free_idx;
    logic none_free;
    logic [LOCKS-1:0] lock_reg;
    logic [LOCKS-1:0] alloc_reg;
    logic [CORES-1:0] req_seen_reg;
    logic [CORES-1:0] ready_reg;
    logic [CORES*4-1:0] lead_reg;

    slot_rotor #(.CORES(CORES), .SLOT_LEN(lock_pool_pkg::SLOT_CLOCKS)) u_rotor (
        .clk_in(REF_CLK_IN),
        .srst_in(SRST_IN),
        .owner_out(owner),
        .slot_start_out(slot_start)
    );

    first_free #(.N(LOCKS), .W(IB)) u_pick (
        .used_in(alloc_reg),
        .idx_out(free_idx),
        .none_out(none_free)
    );

    // ************************************************************
    // per-core decode and lead-in counter
    // ************************************************************
    logic [CORES-1:0] is_clr, is_new, is_ret, is_set, valid_op;
    logic [IB-1:0] core_id [CORES];
    genvar g;
    generate
        for (g = 0; g < CORES; g++) begin : g_core
            wire hub = (INSTR_IN[g*6 +: 6] == lock_pool_pkg::HUB_INSTR);
            assign is_clr[g] = hub && SRC_IN[g*3 +: 3] == lock_pool_pkg::SRC_CLEAR;
            assign is_new[g] = hub && SRC_IN[g*3 +: 3] == lock_pool_pkg::SRC_CHECKOUT;
            assign is_ret[g] = hub && SRC_IN[g*3 +: 3] == lock_pool_pkg::SRC_RELEASE;
            assign is_set[g] = hub && SRC_IN[g*3 +: 3] == lock_pool_pkg::SRC_SET;
            assign valid_op[g] = is_clr[g] | is_new[g] | is_ret[g] | is_set[g];
            assign core_id[g] = ID_IN[g*32 +: IB];

            // a fixed lead-in gives the 7-clock floor; slot wait adds the rest
            always_ff @(posedge REF_CLK_IN) begin
                if (SRST_IN) begin
                    lead_reg[g*4 +: 4] <= 4'h0;
                    ready_reg[g] <= 1'b0;
                    req_seen_reg[g] <= 1'b0;
                end else if (DONE_OUT[g] || !REQ_IN[g]) begin
                    lead_reg[g*4 +: 4] <= 4'h0;
                    ready_reg[g] <= 1'b0;
                    req_seen_reg[g] <= 1'b0;
                end else if (!req_seen_reg[g]) begin
                    req_seen_reg[g] <= 1'b1;
                end else if (lead_reg[g*4 +: 4] == 4'(LEAD - 1)) begin
                    ready_reg[g] <= 1'b1;
                end else begin
                    lead_reg[g*4 +: 4] <= lead_reg[g*4 +: 4] + 4'h1;
                end
            end
        end
    endgenerate

    // only the slot owner acts, and only at the slot's first clock
    wire serve = slot_start && ready_reg[owner] && !DONE_OUT[owner] && REQ_IN[owner];
    wire [IB-1:0] sid = core_id[owner];

    // ************************************************************
    // lock and allocation state
    // ************************************************************
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            lock_reg <= lock_pool_pkg::LOCKS_RESET;
        end else if (serve && is_clr[owner]) begin
            lock_reg[sid] <= 1'b0;
        end else if (serve && is_set[owner]) begin
            lock_reg[sid] <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            alloc_reg <= lock_pool_pkg::LOCKS_RESET;
        end else if (serve && is_new[owner] && !none_free) begin
            alloc_reg[free_idx] <= 1'b1;
        end else if (serve && is_ret[owner]) begin
            alloc_reg[sid] <= 1'b0;
        end
    end

    // ************************************************************
    // per-core answer
    // ************************************************************
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            DONE_OUT <= '0;
            ZERO_WE_OUT <= '0;
            ZERO_OUT <= '0;
            CARRY_WE_OUT <= '0;
            CARRY_OUT <= '0;
            DEST_WE_OUT <= '0;
            ALLOCATED_ID_REGISTER_OUT <= '0;
        end else begin
            DONE_OUT <= '0;
            ZERO_WE_OUT <= '0;
            CARRY_WE_OUT <= '0;
            DEST_WE_OUT <= '0;
            if (serve) begin
                DONE_OUT[owner] <= 1'b1;
                if (!valid_op[owner]) begin
                    // unknown source: complete with no effect so the core is not stuck
                    ZERO_WE_OUT[owner] <= 1'b0;
                end else if (is_new[owner]) begin
                    ZERO_WE_OUT[owner] <= ZERO_FLAG_WRITE_EFFECT_IN[owner];
                    ZERO_OUT[owner] <= (free_idx == '0) && !none_free;
                    CARRY_WE_OUT[owner] <= CARRY_FLAG_WRITE_EFFECT_IN[owner];
                    CARRY_OUT[owner] <= none_free;
                    DEST_WE_OUT[owner] <= RESULT_WRITE_IN[owner];
                    // full pool reports 7, the highest ID
                    ALLOCATED_ID_REGISTER_OUT[owner*32 +: 32] <=
                        none_free ? 32'(LOCKS - 1) : 32'(free_idx);
                end else begin
                    ZERO_WE_OUT[owner] <= ZERO_FLAG_WRITE_EFFECT_IN[owner];
                    ZERO_OUT[owner] <= (sid == '0);
                    CARRY_WE_OUT[owner] <= CARRY_FLAG_WRITE_EFFECT_IN[owner];
                    CARRY_OUT[owner] <= is_ret[owner] ? (&alloc_reg) : lock_reg[sid];
                    DEST_WE_OUT[owner] <= RESULT_WRITE_IN[owner];
                    ALLOCATED_ID_REGISTER_OUT[owner*32 +: 32] <= 32'(sid);
                end
            end
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            LOCK_STATE_OUT <= '0;
            LOCK_ALLOC_OUT <= '0;
        end else begin
            LOCK_STATE_OUT <= lock_reg;
            LOCK_ALLOC_OUT <= alloc_reg;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    logic [5:0] wait_cnt [CORES];
    generate
        for (g = 0; g < CORES; g++) begin : g_wait
            always_ff @(posedge REF_CLK_IN) begin
                if (SRST_IN || !REQ_IN[g] || DONE_OUT[g]) begin
                    wait_cnt[g] <= 6'h00;
                end else begin
                    wait_cnt[g] <= wait_cnt[g] + 6'h01;
                end
            end
            a_done_window: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
                DONE_OUT[g] |-> (wait_cnt[g] >= 6'(lock_pool_pkg::MIN_CLOCKS)
                && wait_cnt[g] <= 6'(lock_pool_pkg::MAX_CLOCKS)))
                else $error("lock op finished outside 7..22 clocks");
        end
    endgenerate

    a_clear_bit: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_clr[owner] |=> !lock_reg[$past(sid)])
        else $error("clear left lock bit set");
    a_clear_carry: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_clr[owner] |=> CARRY_OUT[$past(owner)] == $past(lock_reg[sid]))
        else $error("clear carry not prior lock state");
    a_clear_zero: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_clr[owner] |=> ZERO_OUT[$past(owner)] == ($past(sid) == 3'h0))
        else $error("clear zero flag wrong");
    a_clear_id: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_clr[owner] |=>
        ALLOCATED_ID_REGISTER_OUT[$past(owner)*32 +: 32] == 32'($past(sid)))
        else $error("clear result ID wrong");
    a_dest_gate: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && (is_clr[owner] || is_ret[owner]) && !RESULT_WRITE_IN[owner]
        |=> DEST_WE_OUT == '0)
        else $error("destination written without result effect");
    a_new_lowest: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_new[owner] && !alloc_reg[0] |=> alloc_reg[0])
        else $error("checkout skipped lowest free lock");
    a_new_full: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_new[owner] && (&alloc_reg) |=> CARRY_OUT[$past(owner)] && $stable(alloc_reg))
        else $error("full pool checkout wrong");
    a_new_zero: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_new[owner] && !none_free |=>
        ZERO_OUT[$past(owner)] == ($past(free_idx) == 3'h0))
        else $error("checkout zero flag wrong");
    a_ret_free: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_ret[owner] |=> !alloc_reg[$past(sid)])
        else $error("release kept lock allocated");
    a_ret_carry: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_ret[owner] |=> CARRY_OUT[$past(owner)] == $past(&alloc_reg))
        else $error("release carry wrong");
    a_one_done: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        $onehot0(DONE_OUT))
        else $error("two cores served at once");

    // ************************************************************
    // checkout, clear, release, strobe, timing and map checks
    // ************************************************************
    a_new_unique: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_new[owner] && !none_free |=> alloc_reg[$past(free_idx)]
        && $countones(alloc_reg) == $countones($past(alloc_reg)) + 1)
        else $error("checkout did not reserve exactly one lock");
    a_new_id: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_new[owner] && !none_free |=>
        ALLOCATED_ID_REGISTER_OUT[$past(owner)*32 +: 32] == 32'($past(free_idx)))
        else $error("checkout result ID wrong");
    a_new_dest: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_new[owner] |=> DEST_WE_OUT[$past(owner)] == $past(RESULT_WRITE_IN[owner]))
        else $error("checkout destination strobe wrong");
    a_full_zero: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_new[owner] && none_free |=> !ZERO_OUT[$past(owner)])
        else $error("full pool checkout raised zero flag");
    a_clear_dest: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_clr[owner] && RESULT_WRITE_IN[owner] |=> DEST_WE_OUT[$past(owner)])
        else $error("clear with result effect did not write");
    a_ret_id: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && is_ret[owner] |=>
        ALLOCATED_ID_REGISTER_OUT[$past(owner)*32 +: 32] == 32'($past(sid)))
        else $error("release result ID wrong");
    a_strobe_gate: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        ((ZERO_WE_OUT | CARRY_WE_OUT | DEST_WE_OUT) & ~DONE_OUT) == '0)
        else $error("flag or destination strobe without done");
    a_unknown_quiet: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve && !valid_op[owner] |=> (ZERO_WE_OUT | CARRY_WE_OUT | DEST_WE_OUT) == '0)
        else $error("unknown source changed core state");
    a_slot_only: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        DONE_OUT != '0 |-> $past(slot_start))
        else $error("done outside a slot start");
    // service lands after the lead-in and no later than one full rotation
    a_serve_time: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        serve |-> wait_cnt[owner] >= 6'(LEAD + 1)
        && wait_cnt[owner] < 6'(LEAD + 1 + ROUND))
        else $error("service outside the slot window");
    a_map_lag: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
        LOCK_STATE_OUT == $past(lock_reg) && LOCK_ALLOC_OUT == $past(alloc_reg))
        else $error("lock map outputs out of step");

    c_clear: cover property (@(posedge REF_CLK_IN) serve && is_clr[owner]);
    c_new_full: cover property (@(posedge REF_CLK_IN) serve && is_new[owner] && none_free);
    c_release: cover property (@(posedge REF_CLK_IN) serve && is_ret[owner] && (&alloc_reg));
    c_new_no_result: cover property (@(posedge REF_CLK_IN)
        serve && is_new[owner] && !RESULT_WRITE_IN[owner]);
    c_two_ready: cover property (@(posedge REF_CLK_IN) !$onehot0(ready_reg));
endmodule

// *** lock_core_model.sv ***
`timescale 1ns/1ps
// far-side core model: one lane of lock requests into the shared pool
// assumes registered done and strobes that stand for one cycle
module lock_core_model (
    input wire logic clk_in, // system clock
    input wire logic done_in, // done pulse
    input wire logic zwe_in, // zero strobe
    input wire logic z_in, // zero value
    input wire logic cwe_in, // carry strobe
    input wire logic c_in, // carry value
    input wire logic dwe_in, // dest strobe
    input wire logic [31:0] res_in, // result word
    output logic req_out, // request level
    output logic [5:0] instr_out, // instruction field
    output logic [2:0] src_out, // immediate source
    output logic [31:0] id_out, // id register
    output logic zw_out, // zero effect
    output logic cw_out, // carry effect
    output logic rw_out // result effect
);
    // ****************
    // captured answer
    // ****************
    int cycles;
    logic [4:0] got;
    logic [31:0] got_id;

    initial begin
        req_out = 1'h0;
        instr_out = 6'h00;
        src_out = 3'h0;
        id_out = 32'h0;
        {zw_out, cw_out, rw_out} = 3'h0;
    end

    task automatic issue(input logic [2:0] s, input logic [31:0] id, input logic [2:0] eff);
        @(posedge clk_in);
        #1;
        instr_out = lock_pool_pkg::HUB_INSTR;
        src_out = s;
        id_out = id;
        {zw_out, cw_out, rw_out} = eff;
        req_out = 1'h1;
        // the next edge is the first to see the request, so it already counts
        cycles = 1;
        @(posedge clk_in);
        #1;
        // fields stay put until the done pulse shows; bounded so a hang cannot stall
        while (done_in !== 1'h1 && cycles < 40) begin
            @(posedge clk_in);
            #1;
            cycles++;
        end
        got = {zwe_in, zwe_in & z_in, cwe_in, cwe_in & c_in, dwe_in};
        got_id = dwe_in ? res_in : 32'h0;
        req_out = 1'h0;
        // released qualifiers carry junk, never the old value
        src_out = ~src_out;
        id_out = ~id_out;
        instr_out = ~instr_out;
    endtask
endmodule

// *** shared_lock_pool_bench.sv ***
`timescale 1ns/1ps
// bench for the shared lock pool: core models on lanes 0 and 5, other lanes idle
// assumes the pool package, design files and core model are compiled first
module shared_lock_pool_bench;
    logic clk;
    logic srst;
    int miscompares = 0;
    int num_checks = 0;
    wire [7:0] done, zwe, zf, cwe, cf, dwe, lst, lal;
    wire [255:0] res;
    wire r0, r1, z0, z1, c0, c1, w0, w1;
    wire [5:0] i0, i1;
    wire [2:0] s0, s1;
    wire [31:0] d0, d1;

    shared_lock_pool dut_u (
        .REF_CLK_IN(clk), .SRST_IN(srst), .REQ_IN({2'h0, r1, 4'h0, r0}),
        .INSTR_IN({12'h000, i1, 24'h000000, i0}), .SRC_IN({6'h00, s1, 12'h000, s0}),
        .ID_IN({64'h0, d1, 128'h0, d0}), .ZERO_FLAG_WRITE_EFFECT_IN({2'h0, z1, 4'h0, z0}),
        .CARRY_FLAG_WRITE_EFFECT_IN({2'h0, c1, 4'h0, c0}),
        .RESULT_WRITE_IN({2'h0, w1, 4'h0, w0}), .DONE_OUT(done), .ZERO_WE_OUT(zwe),
        .ZERO_OUT(zf), .CARRY_WE_OUT(cwe), .CARRY_OUT(cf), .DEST_WE_OUT(dwe),
        .ALLOCATED_ID_REGISTER_OUT(res), .LOCK_STATE_OUT(lst), .LOCK_ALLOC_OUT(lal));

    lock_core_model m0 (.clk_in(clk), .done_in(done[0]), .zwe_in(zwe[0]), .z_in(zf[0]),
        .cwe_in(cwe[0]), .c_in(cf[0]), .dwe_in(dwe[0]), .res_in(res[31:0]), .req_out(r0),
        .instr_out(i0), .src_out(s0), .id_out(d0), .zw_out(z0), .cw_out(c0), .rw_out(w0));
    lock_core_model m1 (.clk_in(clk), .done_in(done[5]), .zwe_in(zwe[5]), .z_in(zf[5]),
        .cwe_in(cwe[5]), .c_in(cf[5]), .dwe_in(dwe[5]), .res_in(res[191:160]), .req_out(r1),
        .instr_out(i1), .src_out(s1), .id_out(d1), .zw_out(z1), .cw_out(c1), .rw_out(w1));

    // ****************
    // shared tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t ns: got %0h, expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_time(input int c);
        chk(32'(c >= lock_pool_pkg::MIN_CLOCKS && c <= lock_pool_pkg::MAX_CLOCKS), 32'h1);
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // map outputs lag the state by one cycle
    task automatic settle();
        @(posedge clk);
        #1;
    endtask

    // one operation on lane 0; flags are {zwe, z, cwe, c, dwe}, z and c masked by strobe
    task automatic op(input logic [2:0] s, input logic [31:0] id, input logic [2:0] eff,
                      input logic [4:0] flags, input logic [31:0] exp_id);
        m0.issue(s, id, eff);
        if (m0.cycles >= 40) begin
            miscompares++;
            results();
        end
        chk_time(m0.cycles);
        chk({27'h0, m0.got}, {27'h0, flags});
        chk(m0.got_id, exp_id);
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic sc_checkout();
        for (int i = 0; i < 8; i++) begin
            op(lock_pool_pkg::SRC_CHECKOUT, 32'h0, 3'h7,
               {1'h1, 1'(i == 0), 3'h5}, 32'(i));
        end
        op(lock_pool_pkg::SRC_CHECKOUT, 32'h0, 3'h7, 5'h17, 32'h7);
        op(lock_pool_pkg::SRC_CHECKOUT, 32'h0, 3'h6, 5'h16, 32'h0);
        settle();
        chk({24'h0, lal}, 32'hFF);
    endtask

    task automatic sc_release();
        op(lock_pool_pkg::SRC_RELEASE, 32'h8, 3'h7, 5'h1F, 32'h0);
        op(lock_pool_pkg::SRC_RELEASE, 32'h5, 3'h6, 5'h14, 32'h0);
        op(lock_pool_pkg::SRC_CHECKOUT, 32'h0, 3'h7, 5'h1D, 32'h0);
        settle();
        chk({24'h0, lal}, 32'hDF);
    endtask

    task automatic sc_clear();
        op(lock_pool_pkg::SRC_SET, 32'h5, 3'h0, 5'h00, 32'h0);
        op(lock_pool_pkg::SRC_CLEAR, 32'h5, 3'h6, 5'h16, 32'h0);
        settle();
        chk({31'h0, lst[5]}, 32'h0);
        op(lock_pool_pkg::SRC_CLEAR, 32'h8, 3'h7, 5'h1D, 32'h0);
        op(lock_pool_pkg::SRC_CLEAR, 32'h1D, 3'h1, 5'h01, 32'h5);
        op(3'h3, 32'h0, 3'h7, 5'h00, 32'h0);
    endtask

    // two cores racing for the last two free locks must get different ones
    task automatic sc_race();
        op(lock_pool_pkg::SRC_RELEASE, 32'h0, 3'h0, 5'h00, 32'h0);
        fork
            m0.issue(lock_pool_pkg::SRC_CHECKOUT, 32'h0, 3'h7);
            m1.issue(lock_pool_pkg::SRC_CHECKOUT, 32'h0, 3'h7);
        join
        if (m0.cycles >= 40 || m1.cycles >= 40) begin
            miscompares++;
            results();
        end
        chk(m0.got_id + m1.got_id, 32'h5);
        chk(32'(m0.got_id != m1.got_id), 32'h1);
        chk({27'h0, m0.got}, {27'h0, 1'h1, 1'(m0.got_id == 32'h0), 3'h5});
        chk({27'h0, m1.got}, {27'h0, 1'h1, 1'(m1.got_id == 32'h0), 3'h5});
        chk_time(m0.cycles);
        chk_time(m1.cycles);
        settle();
        chk({24'h0, lal}, 32'hFF);
    endtask

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        srst = 1'h1;
        repeat (6) @(posedge clk);
        #1;
        srst = 1'h0;
        chk({16'h0, lst, lal}, {24'h0, lock_pool_pkg::LOCKS_RESET});
        sc_checkout();
        sc_release();
        sc_clear();
        sc_race();
        results();
    end
endmodule
